// >>> acpc_clock_cfg.sv
`timescale 1ns/1ns
// Operation
// - In slave auto mode with the PLL bypassed, root clock is bit clock when the select bit is 0 and master clock when 1.
// - In master auto mode, the frequency mode bit picks the separate frequency field at 0 and the frame-sync multiple at 1.
// - The three-bit ratio field maps 0..7 to 64, 256, 384, 512, 768, 1024, 1536, 2304, resetting to 2.
// - The ratio applies only in master mode or in slave mode with master clock as root.
// - In master mode the invert bit inverts the bit clock used for frame-sync generation only.
// - The two-bit divider picks base, half, quarter or double of the base microphone clock rate.
// - Edge select 0 latches channel 1 on falling and channel 2 on rising edge; 1 swaps them.
module acpc_clock_cfg (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic master_mode,
	input wire logic auto_clock_cfg,
	input wire logic auto_mode_pll_bypass,
	input wire logic rate_family_44k,
	input wire logic mic_enable,
	input wire logic bitclock_pin,
	input wire logic mic_data_pin,
	output acpc_pkg::acpc_clk_cfg_t clk_cfg,
	output logic frame_gen_bitclock,
	output logic mic_clock_out,
	output acpc_pkg::acpc_mic_pair_t mic_bits,
	output logic mic_bits_valid
);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// Decode of the master-clock to frame-sync ratio code.
	function automatic logic [11:0] ratio_decode(input logic [2:0] code);
		logic [11:0] r;
		r = 12'h000;
		case (code)
			3'h0: r = 12'h040;
			3'h1: r = 12'h100;
			3'h2: r = 12'h180;
			3'h3: r = 12'h200;
			3'h4: r = 12'h300;
			3'h5: r = 12'h400;
			3'h6: r = 12'h600;
			default: r = 12'h900;
		endcase
		return r;
	endfunction : ratio_decode

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	logic [7:0] clock_source_config_r;
	logic [7:0] mic_clk_r;
	logic [7:0] mic_edge_r;
	logic [7:0] reg_rdata_r;

	// Reserved bits are stored as written, except in the edge register, where
	// only bits 7:6 are kept; elsewhere their reset pattern is the writer's duty.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clock_source_config_r <= acpc_pkg::ACPC_RST_CLOCK_SOURCE_CONFIG;
			mic_clk_r <= acpc_pkg::ACPC_RST_MIC_CLK;
			mic_edge_r <= acpc_pkg::ACPC_RST_MIC_EDGE;
		end else if (reg_wr) begin
			case (reg_addr)
				acpc_pkg::ACPC_ADDR_CLOCK_SOURCE_CONFIG: begin
					clock_source_config_r <= reg_wdata;
				end
				acpc_pkg::ACPC_ADDR_MIC_CLK: begin
					mic_clk_r <= reg_wdata;
				end
				acpc_pkg::ACPC_ADDR_MIC_EDGE: begin
					mic_edge_r <= reg_wdata & acpc_pkg::ACPC_MIC_EDGE_WMASK;
				end
				default: begin
				end
			endcase
		end
	end

	// Read data is registered, one cycle after the address; unmapped
	// addresses read as zero.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_r <= 8'h00;
		end else begin
			case (reg_addr)
				acpc_pkg::ACPC_ADDR_CLOCK_SOURCE_CONFIG: reg_rdata_r <= clock_source_config_r;
				acpc_pkg::ACPC_ADDR_MIC_CLK: reg_rdata_r <= mic_clk_r;
				acpc_pkg::ACPC_ADDR_MIC_EDGE: reg_rdata_r <= mic_edge_r;
				default: reg_rdata_r <= 8'h00;
			endcase
		end
	end

	assign reg_rdata = reg_rdata_r;

	// ------------------------------------------------------------------
	// Clock source configuration
	// ------------------------------------------------------------------
	logic root_sel_bit;
	logic slave_root_mclk;
	acpc_pkg::acpc_clk_cfg_t clk_cfg_nxt;
	acpc_pkg::acpc_clk_cfg_t clk_cfg_r;

	assign root_sel_bit = clock_source_config_r[acpc_pkg::ACPC_BIT_ROOT_SEL];
	// Root selection only matters in slave auto mode with the PLL bypassed.
	assign slave_root_mclk = !master_mode && auto_clock_cfg &&
		auto_mode_pll_bypass && root_sel_bit;

	// Decoded configuration for the clock tree.
	always_comb begin
		clk_cfg_nxt.root_source = slave_root_mclk ?
			acpc_pkg::ACPC_ROOT_MASTERCLOCK :
			acpc_pkg::ACPC_ROOT_BITCLOCK;
		clk_cfg_nxt.freq_from_ratio = master_mode && auto_clock_cfg &&
			clock_source_config_r[acpc_pkg::ACPC_BIT_FREQ_MODE];
		clk_cfg_nxt.ratio_apply = master_mode || slave_root_mclk;
		clk_cfg_nxt.mclk_fs_ratio = ratio_decode(
			clock_source_config_r[acpc_pkg::ACPC_RATIO_HI:acpc_pkg::ACPC_RATIO_LO]
		);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_cfg_r <= '0;
		end else begin
			clk_cfg_r <= clk_cfg_nxt;
		end
	end

	assign clk_cfg = clk_cfg_r;

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic [1:0] bclk_sync_r;
	logic [1:0] mdat_sync_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bclk_sync_r <= 2'h0;
			mdat_sync_r <= 2'h0;
		end else begin
			bclk_sync_r <= {bclk_sync_r[0], bitclock_pin};
			mdat_sync_r <= {mdat_sync_r[0], mic_data_pin};
		end
	end

	// ------------------------------------------------------------------
	// Frame-sync bit clock
	// ------------------------------------------------------------------
	logic frame_gen_bitclock_r;

	// Inversion touches only the copy that feeds frame-sync generation.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_gen_bitclock_r <= 1'b0;
		end else begin
			frame_gen_bitclock_r <= bclk_sync_r[1] ^ (master_mode &&
				clock_source_config_r[acpc_pkg::ACPC_BIT_BCLK_INV]);
		end
	end

	assign frame_gen_bitclock = frame_gen_bitclock_r;

	// ------------------------------------------------------------------
	// Microphone clock generator
	// ------------------------------------------------------------------
	// A phase accumulator is used because 250 MHz has no integer ratio to
	// either audio family; edges jitter by one system cycle at most.
	logic [31:0] base_step;
	logic [31:0] step;
	logic [32:0] acc_sum;
	logic [31:0] acc_r;
	logic mic_clock_out_r;
	logic toggle;

	assign base_step = rate_family_44k ? acpc_pkg::ACPC_STEP_44K :
		acpc_pkg::ACPC_STEP_48K;

	// Divider code scales the step; value 3 doubles the base rate.
	always_comb begin
		case (mic_clk_r[acpc_pkg::ACPC_DIV_HI:acpc_pkg::ACPC_DIV_LO])
			acpc_pkg::ACPC_DIV_BASE: step = base_step;
			acpc_pkg::ACPC_DIV_HALF: step = base_step >> 1;
			acpc_pkg::ACPC_DIV_QUARTER: step = base_step >> 2;
			default: step = base_step << 1;
		endcase
	end

	assign acc_sum = {1'b0, acc_r} + {1'b0, step};
	assign toggle = acc_sum[32];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_r <= 32'h0;
			mic_clock_out_r <= 1'b0;
		end else if (!mic_enable) begin
			acc_r <= 32'h0;
			mic_clock_out_r <= 1'b0;
		end else begin
			acc_r <= acc_sum[31:0];
			if (toggle) begin
				mic_clock_out_r <= !mic_clock_out_r;
			end
		end
	end

	assign mic_clock_out = mic_clock_out_r;

	// ------------------------------------------------------------------
	// Microphone data capture
	// ------------------------------------------------------------------
	logic rise_evt;
	logic fall_evt;
	logic ch1_evt;
	logic ch2_evt;
	acpc_pkg::acpc_mic_pair_t mic_bits_r;
	logic mic_bits_valid_r;

	assign rise_evt = mic_enable && toggle && !mic_clock_out_r;
	assign fall_evt = mic_enable && toggle && mic_clock_out_r;
	// Edge select swaps which edge feeds which channel.
	assign ch1_evt = mic_edge_r[acpc_pkg::ACPC_BIT_EDGE_SEL] ?
		rise_evt : fall_evt;
	assign ch2_evt = mic_edge_r[acpc_pkg::ACPC_BIT_EDGE_SEL] ?
		fall_evt : rise_evt;

	// A pair is reported once both channels of one period are held.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mic_bits_r <= '0;
			mic_bits_valid_r <= 1'b0;
		end else begin
			mic_bits_valid_r <= ch2_evt;
			if (ch1_evt) begin
				mic_bits_r.ch1 <= mdat_sync_r[1];
			end
			if (ch2_evt) begin
				mic_bits_r.ch2 <= mdat_sync_r[1];
			end
		end
	end

	assign mic_bits = mic_bits_r;
	assign mic_bits_valid = mic_bits_valid_r;

endmodule : acpc_clock_cfg

// >>> acpc_clock_cfg_asserts.sv
`timescale 1ns/1ns
// ----
// Port checks
// ----
module acpc_clock_cfg_asserts (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic master_mode,
	input wire logic mic_enable,
	input wire logic bitclock_pin,
	input wire acpc_pkg::acpc_clk_cfg_t clk_cfg,
	input wire logic frame_gen_bitclock,
	input wire logic mic_clock_out,
	input wire logic mic_bits_valid
);
	localparam logic [11:0] rt [8] = '{12'h040, 12'h100, 12'h180, 12'h200,
		12'h300, 12'h400, 12'h600, 12'h900};
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// A lone write, so the decode two edges later belongs to it alone.
	sequence wr_src;
		reg_wr && reg_addr == 8'h16 ##1 !(reg_wr && reg_addr == 8'h16);
	endsequence
	sequence wr_mic;
		reg_wr && reg_addr == 8'h1f ##1 reg_addr == 8'h1f && !reg_wr;
	endsequence
	ratio_decode_a: assert property (wr_src |=>
		clk_cfg.mclk_fs_ratio == rt[$past(reg_wdata[5:3], 2)]) else $error("ratio");
	mic_readback_a: assert property (wr_mic |=>
		reg_rdata == $past(reg_wdata, 2)) else $error("readback");
	edge_zero_a: assert property (reg_addr == 8'h20 |=>
		reg_rdata[5:0] == 6'h00) else $error("edge reserved");
	mic_stop_a: assert property (!mic_enable |=> !mic_clock_out)
		else $error("mic stop");
	fgen_slave_a: assert property ((!master_mode && bitclock_pin)[*5] |->
		frame_gen_bitclock) else $error("frame clock");
	valid_pulse_a: assert property (mic_bits_valid |=> !mic_bits_valid)
		else $error("valid pulse");
	half_min_a: assert property ($rose(mic_clock_out) |->
		(mic_clock_out || !mic_enable)[*8]) else $error("short half");
	toggle_max_a: assert property ($fell(mic_clock_out) && mic_enable |->
		##[1:400] (mic_clock_out || !mic_enable)) else $error("no toggle");
endmodule : acpc_clock_cfg_asserts

bind acpc_clock_cfg acpc_clock_cfg_asserts acpc_clock_cfg_asserts_i (
	.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .master_mode(master_mode),
	.mic_enable(mic_enable), .bitclock_pin(bitclock_pin), .clk_cfg(clk_cfg),
	.frame_gen_bitclock(frame_gen_bitclock), .mic_clock_out(mic_clock_out),
	.mic_bits_valid(mic_bits_valid));

// >>> acpc_clock_cfg_tb_top.sv
`timescale 1ns/1ns
// ----
// Bench
// ----
module acpc_clock_cfg_tb_top;
	logic clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, master_mode = 1'h0;
	logic auto_clock_cfg = 1'h1, auto_mode_pll_bypass = 1'h1;
	logic rate_family_44k = 1'h0, mic_enable = 1'h0, bitclock_pin = 1'h0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic mic_data_pin, frame_gen_bitclock, mic_clock_out, mic_bits_valid;
	logic [1:0] pat = 2'h2;
	acpc_pkg::acpc_clk_cfg_t clk_cfg;
	acpc_pkg::acpc_mic_pair_t mic_bits;
	logic [11:0] rt [8] = '{12'h040, 12'h100, 12'h180, 12'h200, 12'h300,
		12'h400, 12'h600, 12'h900};
	real mt [4] = '{1.0, 0.5, 0.25, 2.0};
	int num_errors = 0, n_tests = 0;
	acpc_clock_cfg acpc_clock_cfg_i (.clk(clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .master_mode(master_mode),
		.auto_clock_cfg(auto_clock_cfg),
		.auto_mode_pll_bypass(auto_mode_pll_bypass),
		.rate_family_44k(rate_family_44k), .mic_enable(mic_enable),
		.bitclock_pin(bitclock_pin), .mic_data_pin(mic_data_pin),
		.clk_cfg(clk_cfg), .frame_gen_bitclock(frame_gen_bitclock),
		.mic_clock_out(mic_clock_out), .mic_bits(mic_bits),
		.mic_bits_valid(mic_bits_valid));
	acpc_mic_model acpc_mic_model_i (.mic_clock_out(mic_clock_out),
		.pat(pat), .mic_data_pin(mic_data_pin));
	initial forever #2 clk = ~clk;
	task automatic chk(input string nm, input logic [15:0] e, g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'h1;
		@(negedge clk);
		reg_wr = 1'h0;
	endtask : wr
	task automatic rd(input logic [7:0] a, e);
		reg_addr = a;
		@(negedge clk);
		chk("rdata", {8'h00, e}, {8'h00, reg_rdata});
	endtask : rd
	// Skip one period so the new divider has fully taken over.
	task automatic per(input real ex);
		real p;
		@(posedge mic_clock_out);
		@(posedge mic_clock_out);
		p = $realtime;
		@(posedge mic_clock_out);
		p = ($realtime - p) / 4.0;
		chk("period", 16'h1, 16'(p > ex - 2.0 && p < ex + 2.0));
	endtask : per
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : give_verdict
	// The whole run needs well under ten thousand cycles.
	initial begin
		#200000;
		num_errors++;
		give_verdict();
	end
	initial begin
		repeat (6) @(negedge clk);
		rst_n = 1'h1;
		rd(8'h16, 8'h10);
		rd(8'h1f, 8'h40);
		rd(8'h20, 8'h00);
		chk("ratio", 16'h0180, 16'(clk_cfg.mclk_fs_ratio));
		for (int i = 0; i < 8; i++) begin
			wr(8'h16, 8'(i << 3));
			rd(8'h16, 8'(i << 3));
			chk("ratio", 16'(rt[i]), 16'(clk_cfg.mclk_fs_ratio));
		end
		$display("test ratio done");
		wr(8'h16, 8'h90);
		rd(8'h16, 8'h90);
		chk("root", 16'h1, 16'(clk_cfg.root_source));
		chk("apply", 16'h1, 16'(clk_cfg.ratio_apply));
		// Without the PLL bypass the root select bit must have no effect.
		auto_mode_pll_bypass = 1'h0;
		repeat (2) @(negedge clk);
		chk("root", 16'h0, 16'(clk_cfg.root_source));
		chk("apply", 16'h0, 16'(clk_cfg.ratio_apply));
		auto_mode_pll_bypass = 1'h1;
		wr(8'h16, 8'h10);
		rd(8'h16, 8'h10);
		chk("root", 16'h0, 16'(clk_cfg.root_source));
		chk("apply", 16'h0, 16'(clk_cfg.ratio_apply));
		master_mode = 1'h1;
		wr(8'h16, 8'h50);
		rd(8'h16, 8'h50);
		chk("apply", 16'h1, 16'(clk_cfg.ratio_apply));
		chk("fmode", 16'h1, 16'(clk_cfg.freq_from_ratio));
		// The frequency mode bit only counts in auto configuration.
		auto_clock_cfg = 1'h0;
		repeat (2) @(negedge clk);
		chk("fmode", 16'h0, 16'(clk_cfg.freq_from_ratio));
		chk("apply", 16'h1, 16'(clk_cfg.ratio_apply));
		auto_clock_cfg = 1'h1;
		bitclock_pin = 1'h1;
		wr(8'h16, 8'h12);
		repeat (5) @(negedge clk);
		chk("fmode", 16'h0, 16'(clk_cfg.freq_from_ratio));
		chk("fgen", 16'h0, 16'(frame_gen_bitclock));
		wr(8'h16, 8'h10);
		repeat (3) @(negedge clk);
		chk("fgen", 16'h1, 16'(frame_gen_bitclock));
		master_mode = 1'h0;
		// In slave mode the invert bit must leave the frame clock alone.
		wr(8'h16, 8'h12);
		repeat (3) @(negedge clk);
		chk("fgen", 16'h1, 16'(frame_gen_bitclock));
		$display("test modes done");
		mic_enable = 1'h1;
		for (int f = 0; f < 2; f++) begin
			for (int d = 0; d < 4; d++) begin
				// Rate family changes only on a falling edge.
				wr(8'h1f, 8'h40 | 8'(d));
				rate_family_44k = f[0];
				per(250000.0 / (f ? 2822.4 : 3072.0) / mt[d]);
			end
		end
		$display("test mic rate done");
		repeat (2) @(posedge mic_bits_valid);
		@(negedge clk);
		chk("bits", 16'h2, 16'(mic_bits));
		wr(8'h20, 8'h80);
		rd(8'h20, 8'h80);
		repeat (2) @(posedge mic_bits_valid);
		@(negedge clk);
		chk("bits", 16'h1, 16'(mic_bits));
		mic_enable = 1'h0;
		repeat (2) @(negedge clk);
		chk("mclk", 16'h0, 16'(mic_clock_out));
		$display("test edges done");
		// A second reset in mid-run must restore every register.
		rst_n = 1'h0;
		repeat (2) @(negedge clk);
		rst_n = 1'h1;
		rd(8'h1f, 8'h40);
		rd(8'h20, 8'h00);
		rd(8'h16, 8'h10);
		chk("ratio", 16'h0180, 16'(clk_cfg.mclk_fs_ratio));
		chk("bits", 16'h0, 16'(mic_bits));
		$display("test reset done");
		give_verdict();
	end
endmodule : acpc_clock_cfg_tb_top

// >>> acpc_mic_model.sv
`timescale 1ns/1ns
// ----
// Two microphones on one data line
// ----
module acpc_mic_model (
	input wire logic mic_clock_out,
	input wire logic [1:0] pat,
	output logic mic_data_pin
);
	// Channel 1 drives after the rise, channel 2 after the fall.
	always @(mic_clock_out) begin
		mic_data_pin <= #1 mic_clock_out ? pat[1] : pat[0];
	end
	initial mic_data_pin = 1'h0;
endmodule : acpc_mic_model

// >>> acpc_pkg.sv
package acpc_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam logic [7:0] ACPC_ADDR_CLOCK_SOURCE_CONFIG = 8'h16;
	localparam logic [7:0] ACPC_ADDR_MIC_CLK = 8'h1f;
	localparam logic [7:0] ACPC_ADDR_MIC_EDGE = 8'h20;

	localparam logic [7:0] ACPC_RST_CLOCK_SOURCE_CONFIG = 8'h10;
	localparam logic [7:0] ACPC_RST_MIC_CLK = 8'h40;
	localparam logic [7:0] ACPC_RST_MIC_EDGE = 8'h00;

	// Writable bits of the edge register; the others read as zero.
	localparam logic [7:0] ACPC_MIC_EDGE_WMASK = 8'hc0;

	// Field positions.
	localparam int ACPC_BIT_ROOT_SEL = 7;
	localparam int ACPC_BIT_FREQ_MODE = 6;
	localparam int ACPC_RATIO_HI = 5;
	localparam int ACPC_RATIO_LO = 3;
	localparam int ACPC_BIT_BCLK_INV = 1;
	localparam int ACPC_DIV_HI = 1;
	localparam int ACPC_DIV_LO = 0;
	localparam int ACPC_BIT_EDGE_SEL = 7;

	// ------------------------------------------------------------------
	// Microphone clock generation
	// ------------------------------------------------------------------
	localparam longint ACPC_SYS_CLK_HZ = 250_000_000;
	localparam longint ACPC_MIC_BASE_44K_HZ = 2_822_400;
	localparam longint ACPC_MIC_BASE_48K_HZ = 3_072_000;
	localparam int ACPC_ACC_W = 32;
	// Phase step for one toggle per accumulator wrap (two per period).
	localparam longint ACPC_STEP_44K_L =
		(2 * ACPC_MIC_BASE_44K_HZ * (64'h1 << ACPC_ACC_W)) / ACPC_SYS_CLK_HZ;
	localparam longint ACPC_STEP_48K_L =
		(2 * ACPC_MIC_BASE_48K_HZ * (64'h1 << ACPC_ACC_W)) / ACPC_SYS_CLK_HZ;
	localparam logic [31:0] ACPC_STEP_44K = ACPC_STEP_44K_L[31:0];
	localparam logic [31:0] ACPC_STEP_48K = ACPC_STEP_48K_L[31:0];

	localparam logic [1:0] ACPC_DIV_BASE = 2'h0;
	localparam logic [1:0] ACPC_DIV_HALF = 2'h1;
	localparam logic [1:0] ACPC_DIV_QUARTER = 2'h2;
	localparam logic [1:0] ACPC_DIV_DOUBLE = 2'h3;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic {
		ACPC_ROOT_BITCLOCK,
		ACPC_ROOT_MASTERCLOCK
	} acpc_root_t;

	typedef struct packed {
		acpc_root_t root_source;
		logic freq_from_ratio;
		logic ratio_apply;
		logic [11:0] mclk_fs_ratio;
	} acpc_clk_cfg_t;

	typedef struct packed {
		logic ch1;
		logic ch2;
	} acpc_mic_pair_t;

endpackage : acpc_pkg
